//--- rtl/ep_csr_store.sv
// Endpoint control/status word store with a registered read port
`default_nettype none
module ep_csr_store (
	// Clock and enable
	input wire logic clk,
	input wire logic ce,
	// Write port
	input wire logic wrEn,
	input wire logic [2:0] wrIdx,
	input wire logic [31:0] wrData,
	// Read port with side data for words held elsewhere
	input wire logic rdEn,
	input wire logic [2:0] rdIdx,
	input wire logic altSel,
	input wire logic [31:0] altData,
	output logic [31:0] rdData
);
	logic [31:0] words [0:usb_dev_pkg::EP_COUNT-1];

	// Array write
	always_ff @(posedge clk) begin
		if (ce && wrEn) begin
			words[wrIdx] <= wrData;
		end
	end

	// Read register: array word or side data
	always_ff @(posedge clk) begin
		if (ce && rdEn) begin
			rdData <= altSel ? altData : words[rdIdx];
		end
	end
endmodule
`default_nettype wire

//--- rtl/usb_dev_pkg.sv
// Package: register map, field positions, timing and carrier types of the USB device-state block
// How it works
// - End of a bus reset sets the unmaskable bus-reset-done flag and raises interrupt.
// - On bus-reset-done, mask and every endpoint control/status register return to reset.
// - Bus inactivity sets suspend flag, interrupts only when masked in; clear register clears.
// - Resume is caught while suspended even with transceiver off; DP pull-up stays on.
// - Detected resume sets the wakeup flag, interrupting only when its mask bit is set.
// - Remote wakeup is allowed only after 5 ms spent in suspend.
// - K state starts within 10 ms of starting to draw wake current.
// - Remote-wakeup K state is held between 1 and 15 ms.
// - K state is made by dropping the DP pull-up and enabling a DM pull-up.
// - Endpoint control/status registers sit every 4 bytes from 0x030, one per endpoint.
// - Endpoint FIFO data registers sit every 4 bytes from 0x050, one per endpoint.
// - While suspended the transceiver-off bit can turn the transceiver off.
// - The 7-bit function address is zero after reset.
// - Function endpoints accept and transfer data only while function enable is set.
`default_nettype none
package usb_dev_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int EP_COUNT = 6;
	// Register offsets
	localparam logic [7:0] FRAME_NUMBER_OFS = 8'h00;
	localparam logic [7:0] DEVICE_STATE_OFS = 8'h04;
	localparam logic [7:0] FUNCTION_ADDRESS_OFS = 8'h08;
	localparam logic [7:0] IRQ_ENABLE_OFS = 8'h10;
	localparam logic [7:0] IRQ_DISABLE_OFS = 8'h14;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'h1C;
	localparam logic [7:0] IRQ_CLEAR_OFS = 8'h20;
	localparam logic [7:0] ENDPOINT_RESET_OFS = 8'h28;
	localparam logic [7:0] EP_CSR_BASE = 8'h30;
	localparam logic [7:0] EP_FIFO_BASE = 8'h50;
	localparam logic [7:0] TRANSCEIVER_CONTROL_OFS = 8'h74;
	localparam logic [7:0] WAKE_CONTROL_OFS = 8'h80;
	localparam logic [7:0] PAD_CONTROL_OFS = 8'h84;
	// Reset values
	localparam logic [31:0] DEVICE_STATE_RESET = 32'h00000000;
	localparam logic [31:0] FUNCTION_ADDRESS_RESET = 32'h00000100;
	localparam logic [31:0] IRQ_MASK_RESET = 32'h00001200;
	localparam logic [31:0] TRANSCEIVER_CONTROL_RESET = 32'h00000100;
	localparam logic [31:0] EP_CSR_RESET = 32'h00000000;
	// Field positions
	localparam int ADDRESS_STATE_ENABLE_BIT = 0;
	localparam int CONFG_BIT = 1;
	localparam int FEN_BIT = 8;
	localparam int ADDRESS_VALUE_FIELD_W = 7;
	localparam int TXOFF_BIT = 8;
	localparam int FRM_ERR_BIT = 16;
	localparam int FRM_OK_BIT = 17;
	localparam int IRQ_SUSPEND_BIT = 8;
	localparam int IRQ_RESUME_BIT = 9;
	localparam int IRQ_SOF_BIT = 11;
	localparam int IRQ_BUSRESET_BIT = 12;
	localparam int IRQ_WAKEUP_BIT = 13;
	localparam logic [31:0] IRQ_VALID_MASK = 32'h00002B3F;
	localparam int WAKE_REQ_BIT = 0;
	localparam int WAKE_SUSP_BIT = 1;
	localparam int WAKE_KDRIVE_BIT = 2;
	localparam int WAKE_READY_BIT = 3;
	localparam int PULLUP_EN_BIT = 0;
	// Timing
	localparam int CLK_HZ = 100000000;
	localparam int CYC_PER_US = CLK_HZ / 1000000;
	localparam int SUSPEND_IDLE_US = 3000;
	localparam int WAKE_WAIT_US = 5000;
	localparam int K_HOLD_US = 5000;
	localparam int SUSPEND_IDLE_CYC = SUSPEND_IDLE_US * CYC_PER_US;
	localparam int WAKE_WAIT_CYC = WAKE_WAIT_US * CYC_PER_US;
	localparam int K_HOLD_CYC = K_HOLD_US * CYC_PER_US;
	localparam int TIMER_W = 21;
	// Carriers
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} busReq_type;
	typedef struct packed {
		logic valid;
		logic ok;
		logic [10:0] frame;
	} sof_type;
	typedef enum logic [1:0] {AWAKE, ASLEEP, KDRIVE} wakeState_type;
endpackage
`default_nettype wire

//--- rtl/usb_device_state_control.sv
// Device-state control and register map of a full-speed USB device port
//
// The plain strobed port was decided locally.
`default_nettype none
module usb_device_state_control #(
	parameter int IDLE_CYCLES = usb_dev_pkg::SUSPEND_IDLE_CYC,
	parameter int WAKE_WAIT_CYCLES = usb_dev_pkg::WAKE_WAIT_CYC,
	parameter int K_HOLD_CYCLES = usb_dev_pkg::K_HOLD_CYC
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Register port
	input wire usb_dev_pkg::busReq_type busReq,
	output logic [31:0] rdData,
	// Link side events
	input wire logic busResetLine,
	input wire logic busActivity,
	input wire logic resumeLine,
	input wire usb_dev_pkg::sof_type sofInfo,
	input wire logic [usb_dev_pkg::EP_COUNT-1:0] epEvent,
	// Pad and status outputs
	output logic irq_ff,
	output logic dpPullup_ff,
	output logic dmPullup_ff,
	output logic wakeCurrent_ff,
	output logic transceiverOff_ff,
	output logic functionEnable_ff,
	output logic [6:0] deviceAddress_ff,
	output logic suspended_ff,
	output logic [usb_dev_pkg::EP_COUNT-1:0] epReset_ff
);
	localparam logic [usb_dev_pkg::TIMER_W-1:0] IDLE_LAST = usb_dev_pkg::TIMER_W'(IDLE_CYCLES - 1);
	localparam logic [usb_dev_pkg::TIMER_W-1:0] WAKE_LAST = usb_dev_pkg::TIMER_W'(WAKE_WAIT_CYCLES - 1);
	localparam logic [usb_dev_pkg::TIMER_W-1:0] K_LAST = usb_dev_pkg::TIMER_W'(K_HOLD_CYCLES - 1);

	// Endpoint slot of an address inside a block of per-endpoint words
	function automatic logic inBlock(input logic [7:0] addr, input logic [7:0] base);
		logic [7:0] diff;
		diff = addr - base;
		inBlock = (addr >= base) && (diff[1:0] == 2'h0) && (diff[7:2] < 6'(usb_dev_pkg::EP_COUNT));
	endfunction

	function automatic logic [2:0] slotOf(input logic [7:0] addr, input logic [7:0] base);
		logic [7:0] diff;
		diff = addr - base;
		slotOf = diff[4:2];
	endfunction

	logic [31:0] deviceState_ff;
	logic [31:0] funcAddr_ff;
	logic [31:0] irqMask_ff;
	logic [31:0] irqStatus_ff;
	logic [31:0] nxt_irqStatus;
	logic [31:0] txControl_ff;
	logic [31:0] frameNumber_ff;
	logic [usb_dev_pkg::EP_COUNT-1:0] epValid_ff;
	logic padControl_ff;
	logic busResetLast_ff;
	logic resumeMeta_ff;
	logic resumeSync_ff;
	logic resumeLast_ff;
	logic [usb_dev_pkg::TIMER_W-1:0] idleCount_ff;
	logic [usb_dev_pkg::TIMER_W-1:0] wakeTimer_ff;
	logic wakeReady_ff;
	usb_dev_pkg::wakeState_type wakeState_ff;
	logic busResetDone;
	logic suspendEvent;
	logic resumeEvent;
	logic wakeRequest;
	logic csrWrite;
	logic csrRead;
	logic [31:0] sideData;
	logic [31:0] irqPending;

	// Decoded events
	assign busResetDone = busResetLast_ff && !busResetLine;
	assign suspendEvent = !suspended_ff && !busActivity && !busResetLine && (idleCount_ff == IDLE_LAST);
	assign resumeEvent = suspended_ff && resumeSync_ff && !resumeLast_ff;
	assign wakeRequest = busReq.wr && (busReq.addr == usb_dev_pkg::WAKE_CONTROL_OFS)
		&& busReq.wdata[usb_dev_pkg::WAKE_REQ_BIT];
	assign csrWrite = busReq.wr && inBlock(busReq.addr, usb_dev_pkg::EP_CSR_BASE);
	assign csrRead = inBlock(busReq.addr, usb_dev_pkg::EP_CSR_BASE) && epValid_ff[slotOf(busReq.addr,
		usb_dev_pkg::EP_CSR_BASE)];
	assign irqPending = irqStatus_ff & (irqMask_ff | (32'h1 << usb_dev_pkg::IRQ_BUSRESET_BIT));

	// Bus reset edge and resume synchroniser
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busResetLast_ff <= 1'b0;
			resumeMeta_ff <= 1'b0;
			resumeSync_ff <= 1'b0;
			resumeLast_ff <= 1'b0;
		end else if (ce) begin
			busResetLast_ff <= busResetLine;
			resumeMeta_ff <= resumeLine;
			resumeSync_ff <= resumeMeta_ff;
			resumeLast_ff <= resumeSync_ff;
		end
	end

	// Idle timer and suspended state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idleCount_ff <= '0;
			suspended_ff <= 1'b0;
		end else if (ce) begin
			if (busActivity || busResetLine || suspended_ff) begin
				idleCount_ff <= '0;
			end else if (!suspendEvent) begin
				idleCount_ff <= idleCount_ff + 1'b1;
			end
			if (suspendEvent) begin
				suspended_ff <= 1'b1;
			end else if (busActivity || busResetLine || resumeEvent || wakeState_ff == usb_dev_pkg::KDRIVE) begin
				suspended_ff <= 1'b0;
			end
		end
	end

	// Remote wakeup sequencer: wait in suspend, then drive K
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wakeState_ff <= usb_dev_pkg::AWAKE;
			wakeTimer_ff <= '0;
			wakeReady_ff <= 1'b0;
		end else if (ce) begin
			unique case (wakeState_ff)
				usb_dev_pkg::AWAKE: begin
					wakeTimer_ff <= '0;
					wakeReady_ff <= 1'b0;
					if (suspendEvent) begin
						wakeState_ff <= usb_dev_pkg::ASLEEP;
					end
				end
				usb_dev_pkg::ASLEEP: begin
					if (!suspended_ff) begin
						wakeState_ff <= usb_dev_pkg::AWAKE;
					end else if (wakeRequest && wakeReady_ff) begin
						wakeState_ff <= usb_dev_pkg::KDRIVE;
						wakeTimer_ff <= '0;
					end else if (wakeTimer_ff == WAKE_LAST) begin
						wakeReady_ff <= 1'b1;
					end else begin
						wakeTimer_ff <= wakeTimer_ff + 1'b1;
					end
				end
				usb_dev_pkg::KDRIVE: begin
					wakeReady_ff <= 1'b0;
					if (wakeTimer_ff == K_LAST) begin
						wakeState_ff <= usb_dev_pkg::AWAKE;
					end else begin
						wakeTimer_ff <= wakeTimer_ff + 1'b1;
					end
				end
				default: begin
					wakeState_ff <= usb_dev_pkg::AWAKE;
				end
			endcase
		end
	end

	// Pads: DP pull-up when pad control enables it and K is not driven, DM pull-up only during K
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dpPullup_ff <= 1'b0;
			dmPullup_ff <= 1'b0;
			wakeCurrent_ff <= 1'b0;
		end else if (ce) begin
			dpPullup_ff <= padControl_ff && !(wakeState_ff == usb_dev_pkg::KDRIVE);
			dmPullup_ff <= wakeState_ff == usb_dev_pkg::KDRIVE;
			wakeCurrent_ff <= wakeState_ff == usb_dev_pkg::KDRIVE;
		end
	end

	// Device state, function address and their bus-reset return
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			deviceState_ff <= usb_dev_pkg::DEVICE_STATE_RESET;
			funcAddr_ff <= usb_dev_pkg::FUNCTION_ADDRESS_RESET;
		end else if (ce) begin
			if (busResetDone) begin
				deviceState_ff <= usb_dev_pkg::DEVICE_STATE_RESET;
				funcAddr_ff <= usb_dev_pkg::FUNCTION_ADDRESS_RESET;
			end else if (busReq.wr) begin
				if (busReq.addr == usb_dev_pkg::DEVICE_STATE_OFS) begin
					if (busReq.wdata[usb_dev_pkg::ADDRESS_STATE_ENABLE_BIT]) begin
						deviceState_ff[usb_dev_pkg::ADDRESS_STATE_ENABLE_BIT] <= 1'b1;
					end
					deviceState_ff[usb_dev_pkg::CONFG_BIT] <= busReq.wdata[usb_dev_pkg::CONFG_BIT];
				end
				if (busReq.addr == usb_dev_pkg::FUNCTION_ADDRESS_OFS) begin
					funcAddr_ff <= busReq.wdata & 32'h0000017F;
				end
			end
		end
	end

	// Mask register: enable sets, disable clears, bus reset restores
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqMask_ff <= usb_dev_pkg::IRQ_MASK_RESET;
		end else if (ce) begin
			if (busResetDone) begin
				irqMask_ff <= usb_dev_pkg::IRQ_MASK_RESET;
			end else if (busReq.wr && busReq.addr == usb_dev_pkg::IRQ_ENABLE_OFS) begin
				irqMask_ff <= irqMask_ff | (busReq.wdata & usb_dev_pkg::IRQ_VALID_MASK);
			end else if (busReq.wr && busReq.addr == usb_dev_pkg::IRQ_DISABLE_OFS) begin
				irqMask_ff <= irqMask_ff & ~busReq.wdata;
			end
		end
	end

	// Status flags: clear register clears event flags, a same-cycle event wins; endpoint bits follow epEvent, bits 5:1 only with function enable
	always_comb begin
		nxt_irqStatus = irqStatus_ff;
		if (busReq.wr && busReq.addr == usb_dev_pkg::IRQ_CLEAR_OFS) begin
			nxt_irqStatus = nxt_irqStatus & ~(busReq.wdata & 32'h00003B00);
		end
		nxt_irqStatus[5:0] = epEvent & {{5{functionEnable_ff}}, 1'b1};
		if (busResetDone) begin
			nxt_irqStatus[usb_dev_pkg::IRQ_BUSRESET_BIT] = 1'b1;
		end
		if (suspendEvent) begin
			nxt_irqStatus[usb_dev_pkg::IRQ_SUSPEND_BIT] = 1'b1;
		end
		if (resumeEvent) begin
			nxt_irqStatus[usb_dev_pkg::IRQ_WAKEUP_BIT] = 1'b1;
			nxt_irqStatus[usb_dev_pkg::IRQ_RESUME_BIT] = 1'b1;
		end
		if (sofInfo.valid) begin
			nxt_irqStatus[usb_dev_pkg::IRQ_SOF_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqStatus_ff <= 32'h00000000;
			irq_ff <= 1'b0;
		end else if (ce) begin
			irqStatus_ff <= nxt_irqStatus;
			irq_ff <= |irqPending;
		end
	end

	// Frame number capture at each start of frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frameNumber_ff <= 32'h00000000;
		end else if (ce && sofInfo.valid) begin
			frameNumber_ff <= {14'h0000, sofInfo.ok, !sofInfo.ok, 5'h00, sofInfo.frame};
		end
	end

	// Transceiver, pad control, endpoint reset lines and outputs of address state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txControl_ff <= usb_dev_pkg::TRANSCEIVER_CONTROL_RESET;
			padControl_ff <= 1'b0;
			epReset_ff <= '0;
			transceiverOff_ff <= 1'b1;
			functionEnable_ff <= 1'b0;
			deviceAddress_ff <= 7'h00;
		end else if (ce) begin
			if (busReq.wr && busReq.addr == usb_dev_pkg::TRANSCEIVER_CONTROL_OFS) begin
				txControl_ff <= busReq.wdata & (32'h1 << usb_dev_pkg::TXOFF_BIT);
			end
			if (busReq.wr && busReq.addr == usb_dev_pkg::PAD_CONTROL_OFS) begin
				padControl_ff <= busReq.wdata[usb_dev_pkg::PULLUP_EN_BIT];
			end
			if (busReq.wr && busReq.addr == usb_dev_pkg::ENDPOINT_RESET_OFS) begin
				epReset_ff <= busReq.wdata[usb_dev_pkg::EP_COUNT-1:0];
			end
			transceiverOff_ff <= txControl_ff[usb_dev_pkg::TXOFF_BIT];
			functionEnable_ff <= funcAddr_ff[usb_dev_pkg::FEN_BIT];
			deviceAddress_ff <= funcAddr_ff[usb_dev_pkg::ADDRESS_VALUE_FIELD_W-1:0];
		end
	end

	// Endpoint words become reset until software writes them again
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			epValid_ff <= '0;
		end else if (ce) begin
			if (busResetDone) begin
				epValid_ff <= '0;
			end else if (csrWrite) begin
				epValid_ff[slotOf(busReq.addr, usb_dev_pkg::EP_CSR_BASE)] <= 1'b1;
			end
		end
	end

	// Read data for every word not held in the endpoint store
	always_comb begin
		sideData = 32'h00000000;
		unique case (busReq.addr)
			usb_dev_pkg::FRAME_NUMBER_OFS: sideData = frameNumber_ff;
			usb_dev_pkg::DEVICE_STATE_OFS: sideData = deviceState_ff;
			usb_dev_pkg::FUNCTION_ADDRESS_OFS: sideData = funcAddr_ff;
			usb_dev_pkg::IRQ_MASK_OFS: sideData = irqMask_ff;
			usb_dev_pkg::IRQ_STATUS_OFS: sideData = irqStatus_ff;
			usb_dev_pkg::ENDPOINT_RESET_OFS: sideData = {26'h0000000, epReset_ff};
			usb_dev_pkg::TRANSCEIVER_CONTROL_OFS: sideData = txControl_ff;
			usb_dev_pkg::PAD_CONTROL_OFS: sideData = {31'h00000000, padControl_ff};
			usb_dev_pkg::WAKE_CONTROL_OFS: begin
				sideData[usb_dev_pkg::WAKE_SUSP_BIT] = suspended_ff;
				sideData[usb_dev_pkg::WAKE_KDRIVE_BIT] = wakeState_ff == usb_dev_pkg::KDRIVE;
				sideData[usb_dev_pkg::WAKE_READY_BIT] = wakeReady_ff;
			end
			default: sideData = 32'h00000000; // FIFO data words and holes read zero
		endcase
		if (inBlock(busReq.addr, usb_dev_pkg::EP_FIFO_BASE)) begin
			sideData = 32'h00000000;
		end
	end

	// Endpoint control/status words live in their own store
	ep_csr_store csrStore (
		.clk(clk),
		.ce(ce),
		.wrEn(csrWrite),
		.wrIdx(slotOf(busReq.addr, usb_dev_pkg::EP_CSR_BASE)),
		.wrData(busReq.wdata),
		.rdEn(busReq.rd),
		.rdIdx(slotOf(busReq.addr, usb_dev_pkg::EP_CSR_BASE)),
		.altSel(!csrRead),
		.altData(inBlock(busReq.addr, usb_dev_pkg::EP_CSR_BASE) ? usb_dev_pkg::EP_CSR_RESET : sideData),
		.rdData(rdData)
	);

	// Checks
	busreset_flag_a: assert property (@(posedge clk) disable iff (rst)
		ce && busResetDone |=> irqStatus_ff[usb_dev_pkg::IRQ_BUSRESET_BIT] ##1 !ce || irq_ff)
		else $error("bus reset done did not raise flag and interrupt");
	mask_restore_a: assert property (@(posedge clk) disable iff (rst)
		ce && busResetDone |=> irqMask_ff == usb_dev_pkg::IRQ_MASK_RESET && epValid_ff == '0)
		else $error("mask or endpoint words not restored on bus reset");
	suspend_flag_a: assert property (@(posedge clk) disable iff (rst)
		ce && $rose(irqStatus_ff[usb_dev_pkg::IRQ_SUSPEND_BIT]) |-> $rose(suspended_ff))
		else $error("suspend flag set without entering suspend");
	suspend_gate_a: assert property (@(posedge clk) disable iff (rst)
		ce && irqStatus_ff[usb_dev_pkg::IRQ_SUSPEND_BIT] && !irqMask_ff[usb_dev_pkg::IRQ_SUSPEND_BIT]
		&& irqPending == 32'h00000000 |=> !ce || !irq_ff)
		else $error("masked suspend flag raised interrupt");
	wakeup_sync_a: assert property (@(posedge clk) disable iff (rst)
		$rose(irqStatus_ff[usb_dev_pkg::IRQ_WAKEUP_BIT]) |-> $past(resumeSync_ff) && $past(suspended_ff))
		else $error("wakeup flag not from synchronised resume");
	kstate_pads_a: assert property (@(posedge clk) disable iff (rst)
		dmPullup_ff |-> !dpPullup_ff && wakeCurrent_ff)
		else $error("K state with DP pull-up still on");
	wake_early_a: assert property (@(posedge clk) disable iff (rst)
		$rose(wakeState_ff == usb_dev_pkg::KDRIVE) |-> $past(wakeReady_ff))
		else $error("remote wakeup before suspend wait");
	khold_len_a: assert property (@(posedge clk) disable iff (rst)
		ce && wakeState_ff == usb_dev_pkg::KDRIVE && wakeTimer_ff == K_LAST |=> wakeState_ff != usb_dev_pkg::KDRIVE)
		else $error("K state hold length wrong");
	idle_suspend_a: assert property (@(posedge clk) disable iff (rst)
		$rose(suspended_ff) |-> $past(idleCount_ff) == IDLE_LAST)
		else $error("suspend declared before idle time");
	fen_gate_a: assert property (@(posedge clk) disable iff (rst)
		ce && !functionEnable_ff && !(busReq.wr && busReq.addr == usb_dev_pkg::IRQ_CLEAR_OFS)
		|=> irqStatus_ff[5:1] == 5'h00)
		else $error("function endpoint event while disabled");
	addr_zero_a: assert property (@(posedge clk) disable iff (rst)
		ce && busResetDone |=> funcAddr_ff[usb_dev_pkg::ADDRESS_VALUE_FIELD_W-1:0] == 7'h00)
		else $error("function address not zero after bus reset");
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the device-state control block
`default_nettype none
`define CHK(what, exp, got) begin \
	nTests++; \
	if ((got) !== (exp)) begin \
		errTotal++; \
		$display("ERROR %s expected %h seen %h", what, exp, got); \
	end \
end
`define WAITON(s, lim) begin \
	cnt = 0; \
	while ((s) !== 1'b1 && cnt < (lim)) begin \
		@(posedge clk); \
		cnt++; \
	end \
end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int IDLE = 20;
	localparam int WAIT = 30;
	localparam int KHOLD = 10;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} row_type;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [1:0] mode = 2'h0;
	logic [5:0] epEvent = 6'h00;
	usb_dev_pkg::busReq_type busReq = '0;
	usb_dev_pkg::sof_type sofInfo;
	logic busResetLine, busActivity, resumeLine, irq_ff, dpPullup_ff, dmPullup_ff, wakeCurrent_ff;
	logic transceiverOff_ff, functionEnable_ff, suspended_ff, seen;
	logic [6:0] deviceAddress_ff;
	logic [5:0] epReset_ff;
	logic [31:0] rdData, got;
	int errTotal = 0;
	int nTests = 0;
	int cnt;
	row_type rows [22] = '{'{0, 8'h18, 32'h1200}, '{0, 8'h08, 32'h100}, '{0, 8'h04, 0}, '{0, 8'h74, 32'h100},
		'{0, 8'h30, 0}, '{0, 8'h44, 0}, '{0, 8'h64, 0}, '{0, 8'h0C, 0}, '{0, 8'h10, 0}, '{1, 8'h84, 1},
		'{1, 8'h64, 32'hA5A5A5A5}, '{0, 8'h64, 0}, '{1, 8'h08, 32'h17F}, '{0, 8'h08, 32'h17F},
		'{1, 8'h10, 32'h2303}, '{1, 8'h14, 32'h2000}, '{1, 8'h18, 32'hFFFFFFFF}, '{0, 8'h18, 32'h1303},
		'{1, 8'h44, 32'h1234}, '{0, 8'h44, 32'h1234}, '{1, 8'h28, 32'h15}, '{0, 8'h28, 32'h15}};
	// Clock runs at 100 MHz
	always #5 clk = ~clk;
	// Clock enable starts on so registers are reachable
	usb_device_state_control #(.IDLE_CYCLES(IDLE), .WAKE_WAIT_CYCLES(WAIT), .K_HOLD_CYCLES(KHOLD)) dut (
		.clk(clk), .rst(rst), .ce(ce), .busReq(busReq), .rdData(rdData),
		.busResetLine(busResetLine), .busActivity(busActivity), .resumeLine(resumeLine), .sofInfo(sofInfo),
		.epEvent(epEvent), .irq_ff(irq_ff), .dpPullup_ff(dpPullup_ff), .dmPullup_ff(dmPullup_ff),
		.wakeCurrent_ff(wakeCurrent_ff), .transceiverOff_ff(transceiverOff_ff),
		.functionEnable_ff(functionEnable_ff), .deviceAddress_ff(deviceAddress_ff),
		.suspended_ff(suspended_ff), .epReset_ff(epReset_ff));
	usb_host_model host (.clk(clk), .rst(rst), .mode(mode), .busResetLine(busResetLine),
		.busActivity(busActivity), .resumeLine(resumeLine), .sofInfo(sofInfo));
	// One-cycle write strobe, then an idle cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		busReq <= '0;
		@(posedge clk);
	endtask
	// One-cycle read strobe; data is taken in the following cycle only
	task automatic rd(input logic [7:0] a);
		busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk);
		busReq <= '0;
		#1;
		got = rdData;
		@(posedge clk);
	endtask
	// Verdict and end of run
	task automatic results;
		if (errTotal == 0 && nTests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Watchdog against a hung sequence
	initial begin
		repeat (4000) @(posedge clk);
		errTotal++;
		results();
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK("address", 7'h00, deviceAddress_ff)
		foreach (rows[k]) begin
			if (rows[k].w) begin
				wr(rows[k].a, rows[k].d);
			end else begin
				rd(rows[k].a);
				`CHK("register", rows[k].d, got)
			end
		end
		`CHK("pullup", 1'b1, dpPullup_ff)
		`CHK("address", 7'h7F, deviceAddress_ff)
		`CHK("epReset", 6'h15, epReset_ff)
		// Endpoint 1 event reaches the interrupt only with function enable set
		for (int k = 0; k < 2; k++) begin
			wr(8'h08, {23'h0, k[0], 8'h7F});
			epEvent <= 6'h02;
			@(posedge clk);
			epEvent <= 6'h00;
			seen = 1'b0;
			repeat (4) begin
				@(posedge clk);
				seen |= irq_ff;
			end
			`CHK("epIrq", k[0], seen)
		end
		wr(8'h14, 32'h3);
		// Bus reset from the host
		mode <= 2'h2;
		repeat (4) @(posedge clk);
		mode <= 2'h0;
		repeat (3) @(posedge clk);
		rd(8'h1C);
		`CHK("resetDone", 32'h1000, got & 32'h1000)
		`CHK("irq", 1'b1, irq_ff)
		rd(8'h18);
		`CHK("mask", 32'h1200, got)
		rd(8'h44);
		`CHK("epWord", 32'h0, got)
		`CHK("address", 7'h00, deviceAddress_ff)
		wr(8'h20, 32'h1000);
		wr(8'h30, 32'h8000);
		wr(8'h74, 32'h0);
		@(posedge clk);
		`CHK("irq", 1'b0, irq_ff)
		`CHK("txOff", 1'b0, transceiverOff_ff)
		// Set address only after the endpoint 0 IN-done event, then configure
		wr(8'h10, 32'h1);
		epEvent <= 6'h01;
		@(posedge clk);
		epEvent <= 6'h00;
		repeat (2) @(posedge clk);
		`CHK("inDone", 1'b1, irq_ff)
		wr(8'h04, 32'h1);
		wr(8'h08, 32'h105);
		rd(8'h04);
		`CHK("addrState", 32'h1, got)
		`CHK("address", 7'h05, deviceAddress_ff)
		`CHK("fen", 1'b1, functionEnable_ff)
		wr(8'h34, 32'hC000);
		wr(8'h04, 32'h3);
		rd(8'h04);
		`CHK("configured", 32'h3, got)
		// Idle bus leads to suspend
		mode <= 2'h1;
		`WAITON(suspended_ff, IDLE + 5)
		`CHK("idleSpan", 1'b1, cnt >= IDLE - 1 && cnt <= IDLE + 3)
		rd(8'h1C);
		`CHK("suspFlag", 32'h100, got & 32'h100)
		`CHK("irq", 1'b0, irq_ff)
		`CHK("pullup", 1'b1, dpPullup_ff)
		wr(8'h10, 32'h100);
		@(posedge clk);
		`CHK("irq", 1'b1, irq_ff)
		wr(8'h74, 32'h100);
		wr(8'h20, 32'h100);
		@(posedge clk);
		`CHK("txOff", 1'b1, transceiverOff_ff)
		`CHK("irq", 1'b0, irq_ff)
		// Host resume with the wakeup bit masked out, then masked in
		wr(8'h14, 32'h200);
		mode <= 2'h3;
		repeat (3) @(posedge clk);
		mode <= 2'h0;
		repeat (3) @(posedge clk);
		rd(8'h1C);
		`CHK("wakeFlag", 32'h2200, got & 32'h2200)
		`CHK("irq", 1'b0, irq_ff)
		wr(8'h10, 32'h2000);
		@(posedge clk);
		`CHK("irq", 1'b1, irq_ff)
		wr(8'h20, 32'h2200);
		wr(8'h74, 32'h0);
		// Remote wakeup: refused too early, then K state for the hold time
		mode <= 2'h1;
		`WAITON(suspended_ff, IDLE + 5)
		wr(8'h80, 32'h1);
		repeat (3) @(posedge clk);
		`CHK("earlyK", 1'b0, dmPullup_ff)
		repeat (WAIT) @(posedge clk);
		rd(8'h80);
		`CHK("ready", 32'h8, got & 32'h8)
		wr(8'h80, 32'h1);
		`WAITON(dmPullup_ff, 3)
		`CHK("kDm", 1'b1, dmPullup_ff)
		`CHK("kDp", 1'b0, dpPullup_ff)
		`CHK("wakeCur", 1'b1, wakeCurrent_ff)
		cnt = 0;
		while (dmPullup_ff === 1'b1 && cnt < 50) begin
			@(posedge clk);
			cnt++;
		end
		`CHK("kHold", 1'b1, cnt >= KHOLD - 1 && cnt <= KHOLD + 1)
		mode <= 2'h0;
		repeat (3) @(posedge clk);
		// Unplugged: transceiver off and clock enable dropped, so an idle bus must not move any state
		wr(8'h74, 32'h100);
		ce <= 1'b0;
		mode <= 2'h1;
		repeat (IDLE + 5) @(posedge clk);
		`CHK("frozen", 1'b0, suspended_ff)
		`CHK("txOff", 1'b1, transceiverOff_ff)
		results();
	end
endmodule
`default_nettype wire

//--- verification/usb_host_model.sv
// Behavioural host behind a hub port: traffic, idle, bus reset and resume on the link lines
`default_nettype none
module usb_host_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bench command: 0 traffic, 1 idle, 2 bus reset, 3 resume
	input wire logic [1:0] mode,
	// Link lines toward the device
	output logic busResetLine,
	output logic busActivity,
	output logic resumeLine,
	output usb_dev_pkg::sof_type sofInfo
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] tick_ff;
	logic [10:0] frame_ff;
	// Line levels follow the command; an idle bus shows no activity at all
	assign busResetLine = (mode == 2'h2);
	assign busActivity = (mode == 2'h0);
	assign resumeLine = (mode == 2'h3);
	assign sofInfo = '{valid: (tick_ff == 5'h1F) && (mode == 2'h0), ok: 1'b1, frame: frame_ff};
	// Frame marker every 32 cycles while traffic runs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_ff <= 5'h00;
			frame_ff <= 11'h000;
		end else begin
			tick_ff <= tick_ff + 5'h01;
			if (sofInfo.valid) begin
				frame_ff <= frame_ff + 11'h001;
			end
		end
	end
endmodule
`default_nettype wire
